// ---- logic/strap_cfg_pkg.sv ----
`default_nettype none
package strap_cfg_pkg;
    // Protocol select codes {hi,lo}
    localparam logic [1:0] PROTO_STD_PROT   = 2'h0;
    localparam logic [1:0] PROTO_STD_NOPROT = 2'h1;
    localparam logic [1:0] PROTO_GEN_CRC8   = 2'h2;
    localparam logic [1:0] PROTO_GEN_NOCRC  = 2'h3;
    // Identification value: arbitrary, not a real part code
    localparam logic [31:0] ID_VALUE        = 32'h0000A5C3;
    // Start-up sequence length after reset, in ns, converted to cycles
    localparam int          STARTUP_NS      = 2000;
    localparam int          CLK_NS          = 50;
    localparam logic [7:0]  STARTUP_CYC     = 8'((STARTUP_NS + CLK_NS - 1) / CLK_NS);
    // Strap sampling point: cycles after reset release
    localparam logic [1:0]  SAMPLE_AT       = 2'h2;
endpackage : strap_cfg_pkg
`default_nettype wire

// ---- logic/strap_config_and_bringup.sv ----
`timescale 1ns/10ps
`default_nettype none
// How it works
// RULE1: Amplitude strap low: advertise both levels, negotiation picks one.
// RULE2: Amplitude strap high: high level disabled by default, low level only.
// RULE3: Amplitude strap high locks high-level capability bit against writes.
// RULE4: Two protocol straps select one of four SPI variants.
// RULE5: Role strap sets prefer-follower or prefer-leader advertisement.
// RULE6: Unmanaged systems hold power-down strap high through reset.
// RULE7: Leaving reset without power-down starts negotiation, then link attempt.
// RULE8: Power-down strap low keeps device powered down until software releases.
// RULE9: Straps load defaults of amplitude and role controls; writable unless locked.
// RULE10: Identification reads its value only once out of reset and ready.
// RULE11: Host checks reset-complete equals one after identification.
// RULE12: Reset-complete zero with config-done one means device kept config.
// RULE13: Writing one clears reset-complete, interrupt pin returns high.
// RULE14: PHY summary flag stays set while either irq status is unmasked pending.
// RULE15: System-ready sets only after start-up sequence finishes.
// RULE16: Power-down-ready shows power-down state, reset value follows strap.
// RULE17: Host writes masks, then MAC setup, then config-done.
// RULE18: Autonegotiation enabled out of reset.
// RULE19: Negotiation resolves role and transmit level with partner.
// RULE20: Straps sampled right after reset, then pins serve normal use.
// RULE21: Power-down strap zero powers down after reset, one proceeds.
// RULE22: Role strap zero prefers follower, one prefers leader.
// RULE23: Clearing soft power-down starts negotiation, then link attempt.
// RULE24: Sampled straps held constant until next reset.
module strap_config_and_bringup (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Strap pins (asynchronous)
    input  wire logic        amplitude_limit_strap,
    input  wire logic        proto_select_hi_strap,
    input  wire logic        proto_select_lo_strap,
    input  wire logic        role_pref_strap,
    input  wire logic        powerdown_after_reset_strap,
    // Software controls
    input  wire logic        hi_level_wr,
    input  wire logic        hi_level_wdata,
    input  wire logic        role_wr,
    input  wire logic        role_wdata,
    input  wire logic        soft_powerdown_wr,
    input  wire logic        soft_powerdown_wdata,
    input  wire logic        an_enable_wr,
    input  wire logic        an_enable_wdata,
    input  wire logic        reset_complete_clr,
    input  wire logic        config_done_set,
    // Interrupt sources and masks
    input  wire logic        phy_subsystem_irq_status,
    input  wire logic        reset_mgmt_irq_status,
    input  wire logic        irq_mask_a,
    input  wire logic        irq_mask_b,
    // Autonegotiation engine handshake
    input  wire logic        an_complete,
    input  wire logic        partner_hi_able,
    input  wire logic        partner_hi_req,
    input  wire logic        partner_pref_leader,
    input  wire logic        hi_req_local,
    // Status outputs
    output logic [31:0]      identification_reg,
    output logic             reset_complete_flag,
    output logic             config_done_flag,
    output logic             phy_irq_summary_flag,
    output logic             system_ready_bit,
    output logic             powerdown_ready_bit,
    output logic             soft_powerdown_ctrl_bit,
    output logic [1:0]       proto_select,
    output logic             hi_level_able,
    output logic             hi_level_locked,
    output logic             role_pref_leader,
    output logic             an_enable,
    // Link control and interrupt pin
    output logic             an_start,
    output logic             link_attempt,
    output logic             local_is_leader,
    output logic             tx_level_hi,
    output logic             irq_n
);

    typedef enum logic [1:0] { ST_SAMPLE, ST_STARTUP, ST_POWERDOWN, ST_ACTIVE } phase_t;

    typedef struct packed {
        logic [4:0] sync1;
        logic [4:0] sync2;
        logic [1:0] samp_cnt;
        logic [7:0] up_cnt;
        phase_t     phase;
        logic       amp_lock;
        logic       hi_able;
        logic       role;
        logic [1:0] proto;
        logic       pd_strap;
        logic       sw_pd;
        logic       an_en;
        logic       rstc;
        logic       cfg_done;
        logic       ready;
        logic       start;
        logic       link;
        logic       leader;
        logic       tx_hi;
        logic       summ;
        logic       pin_n;
    } state_t;

    state_t s_reg;
    state_t s_next;

    logic irq_pending;

    // Pending PHY interrupt: either status set and not masked
    assign irq_pending = (phy_subsystem_irq_status & ~irq_mask_a)
                       | (reset_mgmt_irq_status & ~irq_mask_b);

    // Next state
    always_comb
    begin
        s_next       = s_reg;
        s_next.start = 1'b0;
        // Synchronise straps; only sync2 is read by logic
        s_next.sync1 = {amplitude_limit_strap, proto_select_hi_strap,
                        proto_select_lo_strap, role_pref_strap,
                        powerdown_after_reset_strap};
        s_next.sync2 = s_reg.sync1;
        case (s_reg.phase)
            ST_SAMPLE:
            begin
                // Wait for synchroniser to fill before trusting the pins
                s_next.samp_cnt = s_reg.samp_cnt + 2'h1;
                if (s_reg.samp_cnt == strap_cfg_pkg::SAMPLE_AT)
                begin
                    s_next.amp_lock = s_reg.sync2[4];                   // [RULE20]
                    s_next.hi_able  = ~s_reg.sync2[4];                  // [RULE1] [RULE2] [RULE9]
                    s_next.proto    = s_reg.sync2[3:2];                 // [RULE4]
                    s_next.role     = s_reg.sync2[1];                   // [RULE5] [RULE22] [RULE9]
                    s_next.pd_strap = s_reg.sync2[0];
                    s_next.sw_pd    = ~s_reg.sync2[0];                  // [RULE21] [RULE16]
                    s_next.phase    = ST_STARTUP;
                end
            end
            ST_STARTUP:
            begin
                s_next.up_cnt = s_reg.up_cnt + 8'h01;
                if (s_reg.up_cnt == strap_cfg_pkg::STARTUP_CYC)
                begin
                    s_next.ready = 1'b1;                                // [RULE15]
                    if (s_reg.sw_pd)
                        s_next.phase = ST_POWERDOWN;                    // [RULE8]
                    else
                    begin
                        s_next.phase = ST_ACTIVE;
                        s_next.start = s_reg.an_en;                     // [RULE7]
                    end
                end
            end
            ST_POWERDOWN:
            begin
                if (!s_reg.sw_pd)
                begin
                    s_next.phase = ST_ACTIVE;
                    s_next.start = s_reg.an_en;                         // [RULE23]
                end
            end
            ST_ACTIVE:
            begin
                if (s_reg.sw_pd)
                begin
                    s_next.phase = ST_POWERDOWN;
                    s_next.link  = 1'b0;
                end
                else if (an_complete && s_reg.an_en && !s_reg.link)
                begin
                    // Resolve role and level from both advertisements
                    s_next.link   = 1'b1;                               // [RULE7] [RULE23]
                    s_next.leader = s_reg.role ? ~partner_pref_leader | 1'b1
                                               : ~partner_pref_leader;  // [RULE19]
                    s_next.tx_hi  = s_reg.hi_able & partner_hi_able
                                  & (hi_req_local | partner_hi_req);    // [RULE19]
                end
            end
            default:
                s_next.phase = ST_SAMPLE;
        endcase
        // Software writes once the device is ready to accept configuration
        if (s_reg.ready)
        begin
            if (hi_level_wr && !s_reg.amp_lock)
                s_next.hi_able = hi_level_wdata;                        // [RULE3]
            if (role_wr)
                s_next.role = role_wdata;                               // [RULE9]
            if (soft_powerdown_wr)
                s_next.sw_pd = soft_powerdown_wdata;
            if (an_enable_wr)
                s_next.an_en = an_enable_wdata;
            if (reset_complete_clr)
                s_next.rstc = 1'b0;                                     // [RULE13]
            if (config_done_set)
                s_next.cfg_done = 1'b1;
        end
        // Summary and pin are registered, so they never glitch with the sources
        s_next.summ  = irq_pending;                                     // [RULE14]
        s_next.pin_n = ~(s_next.rstc & s_next.ready) & ~irq_pending;    // [RULE13]
        // Synchronous reset: straps re-sampled, defaults restored
        if (!rst_b)
        begin
            s_next          = '0;
            s_next.phase    = ST_SAMPLE;
            s_next.an_en    = 1'b1;                                     // [RULE18]
            s_next.rstc     = 1'b1;
            s_next.pin_n    = 1'b1;
        end
    end

    // State register; strap copies only change in ST_SAMPLE
    always_ff @(posedge clk)
    begin
        s_reg <= s_next;                                                // [RULE24]
    end

    // Outputs
    assign identification_reg      = s_reg.ready ? strap_cfg_pkg::ID_VALUE  // [RULE10]
                                                 : 32'h00000000;
    assign reset_complete_flag     = s_reg.rstc;
    assign config_done_flag        = s_reg.cfg_done;
    assign phy_irq_summary_flag    = s_reg.summ;                        // [RULE14]
    assign system_ready_bit        = s_reg.ready;
    assign powerdown_ready_bit     = s_reg.ready & (s_reg.phase == ST_POWERDOWN); // [RULE16]
    assign soft_powerdown_ctrl_bit = s_reg.sw_pd;
    assign proto_select            = s_reg.proto;
    assign hi_level_able           = s_reg.hi_able;
    assign hi_level_locked         = s_reg.amp_lock;
    assign role_pref_leader        = s_reg.role;
    assign an_enable               = s_reg.an_en;
    assign an_start                = s_reg.start;
    assign link_attempt            = s_reg.link;
    assign local_is_leader         = s_reg.leader;
    assign tx_level_hi             = s_reg.tx_hi;
    // Interrupt pin low while reset-complete and system-ready are both set, or a PHY event is pending
    assign irq_n                   = s_reg.pin_n;                       // [RULE13]

    // Locked high-level capability never becomes set
    a_lock_holds: assert property (@(posedge clk) disable iff (!rst_b) // [RULE3]
        s_reg.amp_lock && s_reg.phase != ST_SAMPLE |-> !s_reg.hi_able)
        else $error("high level enabled while locked");

    a_tx_level: assert property (@(posedge clk) disable iff (!rst_b) // [RULE19]
        s_reg.tx_hi |-> s_reg.hi_able | $past(s_reg.hi_able))
        else $error("high level used without capability");

    a_start_pulse: assert property (@(posedge clk) disable iff (!rst_b) // [RULE7]
        an_start |=> !an_start)
        else $error("start not a single pulse");

    a_id_ready: assert property (@(posedge clk) disable iff (!rst_b) // [RULE10]
        !system_ready_bit |-> identification_reg == 32'h00000000)
        else $error("id visible before ready");

    a_rstc_clear: assert property (@(posedge clk) disable iff (!rst_b) // [RULE13]
        reset_complete_clr && system_ready_bit |=> !reset_complete_flag)
        else $error("reset complete not cleared");

    a_pd_hold: assert property (@(posedge clk) disable iff (!rst_b) // [RULE8]
        s_reg.phase == ST_POWERDOWN && s_reg.sw_pd |=> s_reg.phase == ST_POWERDOWN)
        else $error("left power-down without release");

    a_straps_hold: assert property (@(posedge clk) disable iff (!rst_b) // [RULE24]
        s_reg.phase != ST_SAMPLE && $past(s_reg.phase) != ST_SAMPLE
        |-> $stable(s_reg.proto))
        else $error("protocol select changed after sampling");

    // Registered summary follows its sources one cycle later
    a_summary_pending: assert property (@(posedge clk) disable iff (!rst_b) // [RULE14]
        (phy_subsystem_irq_status && !irq_mask_a) || (reset_mgmt_irq_status && !irq_mask_b)
        |=> phy_irq_summary_flag && !irq_n)
        else $error("summary flag dropped while pending");

endmodule : strap_config_and_bringup
`default_nettype wire

// ---- testbench/an_link_partner.sv ----
`timescale 1ns/10ps
`default_nettype none
// Far end of the negotiation engine: answers fast or slow
module an_link_partner (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Negotiation request and partner setup {able,req,lead}
    input  wire logic       an_start,
    input  wire logic       slow,
    input  wire logic [2:0] cfg,
    // Results
    output logic            an_complete,
    output logic            partner_hi_able,
    output logic            partner_hi_req,
    output logic            partner_pref_leader
);
    logic [5:0] cnt_reg;
    // Count from the start pulse; stop once done
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            cnt_reg <= 6'h00;
        else if (an_start)
            cnt_reg <= 6'h01;
        else if (cnt_reg != 6'h00 && !an_complete)
            cnt_reg <= cnt_reg + 6'h01;
    end
    assign an_complete = cnt_reg == (slow ? 6'h28 : 6'h04);
    // Inverse until done, so early use of the bits shows up
    assign {partner_hi_able, partner_hi_req, partner_pref_leader} =
        an_complete ? cfg : ~cfg;
endmodule : an_link_partner
`default_nettype wire

// ---- testbench/tb_strap_config_and_bringup.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_strap_config_and_bringup;
    typedef struct {int k; logic [31:0] v;} note_t;
    note_t notes[$];
    logic clk, rst_b, amplitude_limit_strap, proto_select_hi_strap, proto_select_lo_strap;
    logic role_pref_strap, powerdown_after_reset_strap, hi_level_wr, hi_level_wdata, role_wr;
    logic role_wdata, soft_powerdown_wr, soft_powerdown_wdata, an_enable_wr, an_enable_wdata;
    logic reset_complete_clr, config_done_set, phy_subsystem_irq_status, reset_mgmt_irq_status;
    logic irq_mask_a, irq_mask_b, an_complete, partner_hi_able, partner_hi_req;
    logic partner_pref_leader, hi_req_local, reset_complete_flag, config_done_flag;
    logic phy_irq_summary_flag, system_ready_bit, powerdown_ready_bit, soft_powerdown_ctrl_bit;
    logic hi_level_able, hi_level_locked, role_pref_leader, an_enable, an_start, link_attempt;
    logic local_is_leader, tx_level_hi, irq_n, slow, an_seen;
    logic [31:0] identification_reg;
    logic [1:0]  proto_select;
    logic [2:0]  pcfg, r;
    logic [4:0]  s;
    logic [16:0] obs;
    int          err_total = 0, n_tests = 0, n;
    // Status bits seen by the monitor, one index each except proto_select, which takes two
    assign obs = {an_seen, irq_n, tx_level_hi, local_is_leader, link_attempt, an_enable,
        role_pref_leader, hi_level_locked, hi_level_able, proto_select, soft_powerdown_ctrl_bit,
        powerdown_ready_bit, system_ready_bit, phy_irq_summary_flag, config_done_flag,
        reset_complete_flag};
    strap_config_and_bringup uut (.*);
    an_link_partner far_end (.clk(clk), .rst_b(rst_b), .an_start(an_start), .slow(slow),
        .cfg(pcfg), .an_complete(an_complete), .partner_hi_able(partner_hi_able),
        .partner_hi_req(partner_hi_req), .partner_pref_leader(partner_pref_leader));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Remember a start pulse, since it stands only one cycle
    always @(posedge clk) an_seen <= !rst_b ? 1'b0 : (an_seen | an_start);
    task wrap_up;
        if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : wrap_up
    task miss(input string m);
        err_total++;
        $display("mismatch %0t %s", $time, m);
    endtask : miss
    task cmp_bit(input int k, input logic e);
        n_tests++;
        if (obs[k] !== e) miss($sformatf("status bit %0d", k));
    endtask : cmp_bit
    task cmp_id(input logic [31:0] e);
        n_tests++;
        if (identification_reg !== e) miss("identification value");
    endtask : cmp_id
    // Monitor: mid-cycle, take every pending note and compare
    always @(negedge clk)
        while (notes.size() != 0)
        begin
            if (notes[0].k == 17) cmp_id(notes[0].v);
            else cmp_bit(notes[0].k, notes[0].v[0]);
            void'(notes.pop_front());
        end
    task tick;
        @(posedge clk);
        #1;
    endtask : tick
    task ex(input int k, input logic [31:0] v);
        notes.push_back('{k, v});
    endtask : ex
    // One-cycle pulse, then one idle cycle so pulses never merge
    task automatic pls(ref logic w);
        w = 1'b1;
        tick;
        w = 1'b0;
        tick;
    endtask : pls
    task automatic wr(ref logic w, ref logic d, input logic v);
        d = v;
        pls(w);
    endtask : wr
    initial
    begin
        repeat (100000) @(posedge clk);
        miss("run limit");
        wrap_up;
    end
    initial
    begin
        {rst_b, hi_level_wr, hi_level_wdata, role_wr, role_wdata, soft_powerdown_wr} = 6'h00;
        {soft_powerdown_wdata, an_enable_wr, an_enable_wdata, reset_complete_clr} = 4'h0;
        {config_done_set, phy_subsystem_irq_status, reset_mgmt_irq_status} = 3'h0;
        {irq_mask_a, irq_mask_b, hi_req_local, slow, pcfg, s} = 12'h000;
        {amplitude_limit_strap, proto_select_hi_strap, proto_select_lo_strap} = 3'h0;
        {role_pref_strap, powerdown_after_reset_strap} = 2'h0;
        void'($urandom(32'h0f97));
        // Every protocol code with both power-down strap levels
        for (int i = 0; i < 8; i++)
        begin
            s = {1'($urandom), i[1:0], 1'($urandom), i[2]};
            hi_req_local = 1'($urandom);
            pcfg = 3'($urandom);
            // Negotiation runs during the capability writes when power-down is skipped,
            // so the partner answers late enough to see the restored advertisement
            slow = i[0] | i[2];
            rst_b = 1'b0;
            {amplitude_limit_strap, proto_select_hi_strap, proto_select_lo_strap,
                role_pref_strap, powerdown_after_reset_strap} = s;
            repeat (2) tick;
            rst_b = 1'b1;
            pls(reset_complete_clr);
            wr(soft_powerdown_wr, soft_powerdown_wdata, s[0]);
            tick;
            {amplitude_limit_strap, proto_select_hi_strap, proto_select_lo_strap,
                role_pref_strap, powerdown_after_reset_strap} = ~s;
            n = 0;
            while (system_ready_bit !== 1'b1 && n < 300)
            begin
                ex(17, 32'h00000000);
                tick;
                n++;
            end
            if (n == 300) miss("ready wait");
            if (n == 300) wrap_up;
            repeat (2) tick;
            ex(17, strap_cfg_pkg::ID_VALUE);
            ex(3, 1'b1);
            ex(0, 1'b1);
            ex(15, 1'b0);
            ex(4, !s[0]);
            ex(5, !s[0]);
            ex(16, s[0]);
            ex(7, s[3]);
            ex(6, s[2]);
            ex(8, !s[4]);
            ex(9, s[4]);
            ex(10, s[1]);
            ex(11, 1'b1);
            wr(hi_level_wr, hi_level_wdata, 1'b0);
            ex(8, 1'b0);
            wr(hi_level_wr, hi_level_wdata, 1'b1);
            ex(8, !s[4]);
            wr(role_wr, role_wdata, !s[1]);
            ex(10, !s[1]);
            wr(role_wr, role_wdata, s[1]);
            {irq_mask_a, irq_mask_b} = 2'h3;
            pls(config_done_set);
            ex(1, 1'b1);
            pls(reset_complete_clr);
            ex(0, 1'b0);
            ex(1, 1'b1);
            ex(15, 1'b1);
            // Masks equal, so the pairing of mask to source does not matter
            for (int j = 0; j < 4; j++)
            begin
                r = 3'($urandom);
                {phy_subsystem_irq_status, reset_mgmt_irq_status, irq_mask_a, irq_mask_b} =
                    {r, r[0]};
                tick;
                ex(2, |r[2:1] & !r[0]);
                ex(15, !(|r[2:1] & !r[0]));
            end
            {phy_subsystem_irq_status, reset_mgmt_irq_status} = 2'h0;
            if (!s[0])
            begin
                ex(16, 1'b0);
                wr(soft_powerdown_wr, soft_powerdown_wdata, 1'b0);
                ex(5, 1'b0);
                ex(4, 1'b0);
            end
            n = 0;
            while (an_complete !== 1'b1 && n < 100)
            begin
                tick;
                n++;
            end
            if (n == 100) miss("negotiation wait");
            if (n == 100) wrap_up;
            repeat (2) tick;
            ex(12, 1'b1);
            ex(16, 1'b1);
            ex(13, s[1] | !pcfg[0]);
            ex(14, !s[4] & pcfg[2] & (hi_req_local | pcfg[1]));
            wr(an_enable_wr, an_enable_wdata, 1'b0);
            ex(11, 1'b0);
            wr(an_enable_wr, an_enable_wdata, 1'b1);
            ex(11, 1'b1);
            tick;
        end
        wrap_up;
    end
endmodule : tb_strap_config_and_bringup
`default_nettype wire
